// ---- design/fault_status_pkg.sv ----
package fault_status_pkg;

  localparam int          PAGE_COUNT      = 2;
  localparam int          PAGE_W          = 1;

  // Command codes of the status bytes
  localparam logic [7:0]  CMD_IOUT_STATUS = 8'h7B;
  localparam logic [7:0]  CMD_INPUT_STATUS = 8'h7C;
  localparam logic [7:0]  CMD_TEMP_STATUS = 8'h7D;
  localparam logic [7:0]  CMD_CML_STATUS  = 8'h7E;
  localparam logic [7:0]  CMD_MFR_STATUS  = 8'h80;

  localparam logic [7:0]  STATUS_RESET    = 8'h00;

  // Output current byte
  localparam int          IOUT_OC_BIT     = 7;
  localparam int          IOUT_UC_BIT     = 4;
  // Input byte
  localparam int          VIN_OV_F_BIT    = 7;
  localparam int          VIN_OV_W_BIT    = 6;
  localparam int          VIN_UV_W_BIT    = 5;
  localparam int          VIN_UV_F_BIT    = 4;
  // Temperature byte
  localparam int          OT_F_BIT        = 7;
  localparam int          OT_W_BIT        = 6;
  localparam int          UT_W_BIT        = 5;
  localparam int          UT_F_BIT        = 4;
  // Communication / logic byte
  localparam int          CML_BAD_CMD_BIT = 7;
  localparam int          CML_BAD_DATA_BIT = 6;
  localparam int          CML_PEC_BIT     = 5;
  localparam int          CML_OTHER_BIT   = 1;
  // Vendor monitor byte
  localparam int          MFR_BUS_W_BIT   = 6;
  localparam int          MFR_MON_UV_W_BIT = 5;
  localparam int          MFR_MON_OV_W_BIT = 4;
  localparam int          MFR_SYNC_BIT    = 3;
  localparam int          MFR_MON_UV_F_BIT = 1;
  localparam int          MFR_MON_OV_F_BIT = 0;

  // Summary bits
  localparam int          SUM_OTHER_BIT   = 9;
  localparam int          SUM_CML_BIT     = 1;

  // Status event inputs per byte group: four, two for current, six for vendor
  localparam int          EVT4_W          = 4;
  localparam int          IOUT_EVT_W      = 2;
  localparam int          MFR_EVT_W       = 6;

  // Monitor margins in tenths of the threshold
  localparam int          MON_SCALE_TENTHS = 10;
  localparam int          MON_UV_TENTHS   = 9;
  localparam int          MON_OV_TENTHS   = 11;

endpackage : fault_status_pkg

// ---- design/sticky_bits.sv ----
`timescale 1ns/100ps
module sticky_bits #(
  parameter int W = 4
) (
  input  wire logic         CLK_SYS_I,
  input  wire logic         RST_I,
  input  wire logic [W-1:0] set_i,
  input  wire logic         clear_i,
  output logic      [W-1:0] flags_o
);

  logic [W-1:0] flags_ff;
  logic [W-1:0] nxt_flags;

  // Set beats a clear in the same cycle so no event is lost
  always_comb begin
    nxt_flags = (clear_i ? '0 : flags_ff) | set_i;
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      flags_ff <= '0;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  assign flags_o = flags_ff;

endmodule : sticky_bits

// ---- design/fault_status_bank.sv ----
`timescale 1ns/100ps
// Behaviour
// - Current byte: overcurrent bit7, undercurrent bit4
// - Current byte paged, read-only, resets zero
// - Input byte bits 7..4: OV/OVW/UVW/UV
// - Input byte global, read-only, resets zero
// - Temperature byte bits 7..4: OT/OTW/UTW/UT
// - Temperature byte paged, read-only, resets zero
// - Comm bit7 on invalid command code
// - Comm bit6 on invalid command data
// - Comm bit5 on packet error check failure
// - Comm bit1 on protected write, other faults
// - Comm byte global, resets zero, unused zero
// - Vendor bit6 on inter-converter bus error
// - Vendor bit5: monitor ten percent under
// - Vendor bit4: monitor ten percent over
// - Vendor bit3 on external sync loss
// - Vendor bit1 undervoltage, bit0 overvoltage
// - Vendor byte global, resets zero, unused zero
// - Summary bit9 when any status bit set
// - Summary bit1 mirrors any comm fault
module fault_status_bank #(
  parameter int PAGES = fault_status_pkg::PAGE_COUNT
) (
  input  wire logic        CLK_SYS_I,
  input  wire logic        RST_I,
  // Command decode side of the transaction engine
  input  wire logic [7:0]  CMD_CODE_I,
  input  wire logic        READ_REQ_I,
  input  wire logic        WRITE_REQ_I,
  input  wire logic        PAGE_I,
  input  wire logic        CLEAR_FAULTS_I,
  // Per-page condition pulses or levels
  input  wire logic [1:0]  IOUT_OC_I,
  input  wire logic [1:0]  IOUT_UC_I,
  input  wire logic [1:0]  OT_FAULT_I,
  input  wire logic [1:0]  OT_WARN_I,
  input  wire logic [1:0]  UT_WARN_I,
  input  wire logic [1:0]  UT_FAULT_I,
  // Global conditions
  input  wire logic        VIN_OV_FAULT_I,
  input  wire logic        VIN_OV_WARN_I,
  input  wire logic        VIN_UV_WARN_I,
  input  wire logic        VIN_UV_FAULT_I,
  input  wire logic        CMD_INVALID_I,
  input  wire logic        DATA_INVALID_I,
  input  wire logic        PEC_ERROR_I,
  input  wire logic        COMM_OTHER_I,
  input  wire logic        INTER_CONVERTER_BUS_ERR_I,
  input  wire logic        SYNC_LOSS_I,
  // Monitor comparison
  input  wire logic [15:0] AUX_VOLTAGE_MONITOR_INPUT_I,
  input  wire logic [15:0] MONITOR_UNDERVOLTAGE_THRESHOLD_I,
  input  wire logic [15:0] MONITOR_OVERVOLTAGE_THRESHOLD_I,
  // Read answer
  output logic      [7:0]  READ_DATA_O,
  output logic             READ_VALID_O,
  output logic             READ_HIT_O,
  // Summary
  output logic             SUMMARY_OTHER_O,
  output logic             SUMMARY_CML_O
);

  // Condition vectors, bit order matches the byte layout high to low
  logic [3:0]  temp_set     [PAGES];
  logic [3:0]  temp_flags   [PAGES];
  logic [1:0]  iout_set     [PAGES];
  logic [1:0]  iout_flags   [PAGES];
  logic [3:0]  input_flags;
  logic [3:0]  cml_flags;
  logic [5:0]  mfr_flags;
  logic [5:0]  mfr_set;
  logic        write_ro;

  logic        mon_uv_fault;
  logic        mon_ov_fault;
  logic        mon_uv_warn;
  logic        mon_ov_warn;
  logic [16:0] uv_tenth;
  logic [16:0] ov_tenth;
  logic [19:0] mon_x10;
  logic [19:0] uv_x9;
  logic [19:0] ov_x11;

  // Any write to one of these read-only codes is a protection fault
  always_comb begin
    write_ro = WRITE_REQ_I &&
      (CMD_CODE_I == fault_status_pkg::CMD_IOUT_STATUS  ||
       CMD_CODE_I == fault_status_pkg::CMD_INPUT_STATUS ||
       CMD_CODE_I == fault_status_pkg::CMD_TEMP_STATUS  ||
       CMD_CODE_I == fault_status_pkg::CMD_CML_STATUS   ||
       CMD_CODE_I == fault_status_pkg::CMD_MFR_STATUS);
  end

  // Ten percent margins compared in tenths to avoid a divider
  always_comb begin
    uv_tenth     = 17'(MONITOR_UNDERVOLTAGE_THRESHOLD_I);
    ov_tenth     = 17'(MONITOR_OVERVOLTAGE_THRESHOLD_I);
    mon_x10      = 20'(AUX_VOLTAGE_MONITOR_INPUT_I) * 20'(fault_status_pkg::MON_SCALE_TENTHS);
    uv_x9        = 20'(uv_tenth) * 20'(fault_status_pkg::MON_UV_TENTHS);
    ov_x11       = 20'(ov_tenth) * 20'(fault_status_pkg::MON_OV_TENTHS);
    mon_uv_fault = AUX_VOLTAGE_MONITOR_INPUT_I < MONITOR_UNDERVOLTAGE_THRESHOLD_I;
    mon_ov_fault = AUX_VOLTAGE_MONITOR_INPUT_I > MONITOR_OVERVOLTAGE_THRESHOLD_I;
    mon_uv_warn  = mon_x10 < uv_x9;
    mon_ov_warn  = mon_x10 > ov_x11;
  end

  always_comb begin
    mfr_set = {INTER_CONVERTER_BUS_ERR_I,
               mon_uv_warn,
               mon_ov_warn,
               SYNC_LOSS_I,
               mon_uv_fault,
               mon_ov_fault};
  end

  // Paged flags, one bank per output channel
  generate
    for (genvar p = 0; p < PAGES; p++) begin : g_page
      assign iout_set[p] = {IOUT_OC_I[p], IOUT_UC_I[p]};
      assign temp_set[p] = {OT_FAULT_I[p], OT_WARN_I[p], UT_WARN_I[p], UT_FAULT_I[p]};

      sticky_bits #(.W(fault_status_pkg::IOUT_EVT_W)) u_iout (
        .CLK_SYS_I (CLK_SYS_I),
        .RST_I     (RST_I),
        .set_i     (iout_set[p]),
        .clear_i   (CLEAR_FAULTS_I),
        .flags_o   (iout_flags[p])
      );

      sticky_bits #(.W(fault_status_pkg::EVT4_W)) u_temp (
        .CLK_SYS_I (CLK_SYS_I),
        .RST_I     (RST_I),
        .set_i     (temp_set[p]),
        .clear_i   (CLEAR_FAULTS_I),
        .flags_o   (temp_flags[p])
      );
    end
  endgenerate

  sticky_bits #(.W(fault_status_pkg::EVT4_W)) u_input (
    .CLK_SYS_I (CLK_SYS_I),
    .RST_I     (RST_I),
    .set_i     ({VIN_OV_FAULT_I, VIN_OV_WARN_I, VIN_UV_WARN_I, VIN_UV_FAULT_I}),
    .clear_i   (CLEAR_FAULTS_I),
    .flags_o   (input_flags)
  );

  sticky_bits #(.W(fault_status_pkg::EVT4_W)) u_cml (
    .CLK_SYS_I (CLK_SYS_I),
    .RST_I     (RST_I),
    .set_i     ({CMD_INVALID_I, DATA_INVALID_I, PEC_ERROR_I, COMM_OTHER_I | write_ro}),
    .clear_i   (CLEAR_FAULTS_I),
    .flags_o   (cml_flags)
  );

  sticky_bits #(.W(fault_status_pkg::MFR_EVT_W)) u_mfr (
    .CLK_SYS_I (CLK_SYS_I),
    .RST_I     (RST_I),
    .set_i     (mfr_set),
    .clear_i   (CLEAR_FAULTS_I),
    .flags_o   (mfr_flags)
  );

  // Byte images, unused bits forced low
  logic [7:0] iout_byte;
  logic [7:0] temp_byte;
  logic [7:0] input_byte;
  logic [7:0] cml_byte;
  logic [7:0] mfr_byte;
  localparam int PAGE_W_L = fault_status_pkg::PAGE_W;
  logic [PAGE_W_L-1:0] page_sel;

  always_comb begin
    page_sel   = PAGE_I;
    iout_byte  = fault_status_pkg::STATUS_RESET;
    temp_byte  = fault_status_pkg::STATUS_RESET;
    input_byte = fault_status_pkg::STATUS_RESET;
    cml_byte   = fault_status_pkg::STATUS_RESET;
    mfr_byte   = fault_status_pkg::STATUS_RESET;
    iout_byte[fault_status_pkg::IOUT_OC_BIT]  = iout_flags[page_sel][1];
    iout_byte[fault_status_pkg::IOUT_UC_BIT]  = iout_flags[page_sel][0];
    temp_byte[fault_status_pkg::OT_F_BIT]     = temp_flags[page_sel][3];
    temp_byte[fault_status_pkg::OT_W_BIT]     = temp_flags[page_sel][2];
    temp_byte[fault_status_pkg::UT_W_BIT]     = temp_flags[page_sel][1];
    temp_byte[fault_status_pkg::UT_F_BIT]     = temp_flags[page_sel][0];
    input_byte[fault_status_pkg::VIN_OV_F_BIT] = input_flags[3];
    input_byte[fault_status_pkg::VIN_OV_W_BIT] = input_flags[2];
    input_byte[fault_status_pkg::VIN_UV_W_BIT] = input_flags[1];
    input_byte[fault_status_pkg::VIN_UV_F_BIT] = input_flags[0];
    cml_byte[fault_status_pkg::CML_BAD_CMD_BIT]  = cml_flags[3];
    cml_byte[fault_status_pkg::CML_BAD_DATA_BIT] = cml_flags[2];
    cml_byte[fault_status_pkg::CML_PEC_BIT]      = cml_flags[1];
    cml_byte[fault_status_pkg::CML_OTHER_BIT]    = cml_flags[0];
    mfr_byte[fault_status_pkg::MFR_BUS_W_BIT]    = mfr_flags[5];
    mfr_byte[fault_status_pkg::MFR_MON_UV_W_BIT] = mfr_flags[4];
    mfr_byte[fault_status_pkg::MFR_MON_OV_W_BIT] = mfr_flags[3];
    mfr_byte[fault_status_pkg::MFR_SYNC_BIT]     = mfr_flags[2];
    mfr_byte[fault_status_pkg::MFR_MON_UV_F_BIT] = mfr_flags[1];
    mfr_byte[fault_status_pkg::MFR_MON_OV_F_BIT] = mfr_flags[0];
  end

  // Read port: answer registered one cycle after the request
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic       rvalid_ff;
  logic       nxt_rvalid;
  logic       rhit_ff;
  logic       nxt_rhit;

  always_comb begin
    nxt_rdata  = fault_status_pkg::STATUS_RESET;
    nxt_rhit   = 1'b0;
    nxt_rvalid = READ_REQ_I;
    if (READ_REQ_I) begin
      nxt_rhit = 1'b1;
      case (CMD_CODE_I)
        fault_status_pkg::CMD_IOUT_STATUS:  nxt_rdata = iout_byte;
        fault_status_pkg::CMD_INPUT_STATUS: nxt_rdata = input_byte;
        fault_status_pkg::CMD_TEMP_STATUS:  nxt_rdata = temp_byte;
        fault_status_pkg::CMD_CML_STATUS:   nxt_rdata = cml_byte;
        fault_status_pkg::CMD_MFR_STATUS:   nxt_rdata = mfr_byte;
        default:                            nxt_rhit  = 1'b0;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      rdata_ff  <= fault_status_pkg::STATUS_RESET;
      rvalid_ff <= 1'b0;
      rhit_ff   <= 1'b0;
    end else begin
      rdata_ff  <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
      rhit_ff   <= nxt_rhit;
    end
  end

  assign READ_DATA_O  = rdata_ff;
  assign READ_VALID_O = rvalid_ff;
  assign READ_HIT_O   = rhit_ff;

  // Summary covers every page, not only the selected one
  logic any_paged;
  always_comb begin
    any_paged = 1'b0;
    for (int p = 0; p < PAGES; p++) begin
      any_paged = any_paged | (|iout_flags[p]) | (|temp_flags[p]);
    end
  end

  assign SUMMARY_OTHER_O = any_paged | (|input_flags) | (|cml_flags) | (|mfr_flags);
  assign SUMMARY_CML_O   = |cml_flags;

endmodule : fault_status_bank

// ---- dv/fault_status_bank_props.sv ----
`timescale 1ns/100ps
module fault_status_bank_props #(
  parameter int PAGES = 2
) (
  input wire logic       CLK_SYS_I,
  input wire logic       RST_I,
  input wire logic [7:0] CMD_CODE_I,
  input wire logic       READ_REQ_I,
  input wire logic       WRITE_REQ_I,
  input wire logic       CLEAR_FAULTS_I,
  input wire logic [1:0] IOUT_OC_I,
  input wire logic [1:0] IOUT_UC_I,
  input wire logic       CMD_INVALID_I,
  input wire logic       DATA_INVALID_I,
  input wire logic       PEC_ERROR_I,
  input wire logic       COMM_OTHER_I,
  input wire logic [7:0] READ_DATA_O,
  input wire logic       READ_VALID_O,
  input wire logic       READ_HIT_O,
  input wire logic       SUMMARY_OTHER_O,
  input wire logic       SUMMARY_CML_O
);
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);
  logic cmd_hit;
  logic ev_cml;
  assign cmd_hit = CMD_CODE_I inside {8'h7B, 8'h7C, 8'h7D, 8'h7E, 8'h80};
  assign ev_cml = CMD_INVALID_I | DATA_INVALID_I | PEC_ERROR_I | COMM_OTHER_I
                | (WRITE_REQ_I & cmd_hit);
  property p_answer; READ_REQ_I |=> READ_VALID_O; endproperty
  a_answer: assert property (p_answer) else $error("no answer to read");
  property p_no_spur; READ_VALID_O |-> $past(READ_REQ_I); endproperty
  a_no_spur: assert property (p_no_spur) else $error("answer without read");
  property p_hit; READ_REQ_I |=> READ_HIT_O == $past(cmd_hit); endproperty
  a_hit: assert property (p_hit) else $error("hit flag wrong");
  property p_refuse; READ_REQ_I && !cmd_hit |=> READ_DATA_O == 8'h00; endproperty
  a_refuse: assert property (p_refuse) else $error("unknown code gave data");
  property p_iout; READ_REQ_I && CMD_CODE_I == 8'h7B |=> (READ_DATA_O & 8'h6F) == 8'h00;
  endproperty
  a_iout: assert property (p_iout) else $error("current byte unused bit set");
  property p_nib; READ_REQ_I && CMD_CODE_I inside {8'h7C, 8'h7D} |=> READ_DATA_O[3:0] == 4'h0;
  endproperty
  a_nib: assert property (p_nib) else $error("low nibble set");
  property p_cml; READ_REQ_I && CMD_CODE_I == 8'h7E |=> (READ_DATA_O & 8'h1D) == 8'h00;
  endproperty
  a_cml: assert property (p_cml) else $error("comm byte unused bit set");
  property p_mfr; READ_REQ_I && CMD_CODE_I == 8'h80 |=> (READ_DATA_O & 8'h84) == 8'h00;
  endproperty
  a_mfr: assert property (p_mfr) else $error("vendor byte unused bit set");
  property p_cml_set; ev_cml |=> SUMMARY_CML_O && SUMMARY_OTHER_O; endproperty
  a_cml_set: assert property (p_cml_set) else $error("comm summary missing");
  property p_other; (|IOUT_OC_I) || (|IOUT_UC_I) |=> SUMMARY_OTHER_O; endproperty
  a_other: assert property (p_other) else $error("summary missing");
  property p_sticky; SUMMARY_OTHER_O && !CLEAR_FAULTS_I |=> SUMMARY_OTHER_O; endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost without clear");
  c_hit: cover property (READ_VALID_O && READ_HIT_O);
  c_cml: cover property ($rose(SUMMARY_CML_O));
  c_clear: cover property (SUMMARY_OTHER_O && CLEAR_FAULTS_I);
endmodule : fault_status_bank_props

bind fault_status_bank fault_status_bank_props #(.PAGES(PAGES)) fault_status_bank_props_inst (.*);

// ---- dv/status_host_model.sv ----
`timescale 1ns/100ps
module status_host_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] data_i,
  input  wire logic       valid_i,
  input  wire logic       hit_i,
  output logic      [7:0] cmd_o = 8'h00,
  output logic            rd_o = 1'b0,
  output logic            wr_o = 1'b0,
  output logic            page_o = 1'b0,
  output logic            clr_o = 1'b0
);
  task automatic rd(input logic [7:0] code, input logic pg, output logic [9:0] ans);
    @(posedge clk_i);
    cmd_o  <= code;
    page_o <= pg;
    rd_o   <= 1'b1;
    @(posedge clk_i);
    rd_o   <= 1'b0;
    // Released lines flip so a stale code cannot pass as held
    cmd_o  <= ~code;
    page_o <= ~pg;
    #1;
    ans = {valid_i, hit_i, data_i};
  endtask : rd
  // Write when w is set, otherwise a fault clear
  task automatic pulse(input logic [7:0] code, input logic w);
    @(posedge clk_i);
    cmd_o <= code;
    wr_o  <= w;
    clr_o <= !w;
    @(posedge clk_i);
    wr_o  <= 1'b0;
    clr_o <= 1'b0;
    cmd_o <= ~code;
  endtask : pulse
endmodule : status_host_model

// ---- dv/fault_status_bank_tb_top.sv ----
`timescale 1ns/100ps
module fault_status_bank_tb_top;
  localparam logic [15:0] TBL [16] = '{16'h7B80, 16'h7B10, 16'h7D80, 16'h7D40, 16'h7D20,
    16'h7D10, 16'h7C80, 16'h7C40, 16'h7C20, 16'h7C10, 16'h7E80, 16'h7E40, 16'h7E20,
    16'h7E02, 16'h8040, 16'h8008};
  localparam logic [7:0]  CODES [5] = '{8'h7B, 8'h7C, 8'h7D, 8'h7E, 8'h80};
  // Monitor value, expected vendor byte; thresholds are 1000 and 2000
  localparam logic [23:0] MON [6] = '{24'h032022, 24'h03B602, 24'h03E800, 24'h07D000,
    24'h083401, 24'h08FC11};
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [21:0] ev = '0;
  logic [15:0] mon = 16'd1500;
  logic [15:0] uv_thr = 16'd1000;
  logic [15:0] ov_thr = 16'd2000;
  logic [15:0] rm, ru, ro;
  logic [7:0]  cmd, data, rc;
  logic        rd, wr, pg, clr, valid, hit, so, sc;
  logic [9:0]  ans;
  int          seed = 82;
  int          n_mismatch = 0;
  int          check_count = 0;
  always #2 clk = ~clk;
  fault_status_bank fault_status_bank_inst (
    .CLK_SYS_I(clk), .RST_I(rst), .CMD_CODE_I(cmd), .READ_REQ_I(rd), .WRITE_REQ_I(wr),
    .PAGE_I(pg), .CLEAR_FAULTS_I(clr), .IOUT_OC_I(ev[1:0]), .IOUT_UC_I(ev[3:2]),
    .OT_FAULT_I(ev[5:4]), .OT_WARN_I(ev[7:6]), .UT_WARN_I(ev[9:8]), .UT_FAULT_I(ev[11:10]),
    .VIN_OV_FAULT_I(ev[12]), .VIN_OV_WARN_I(ev[13]), .VIN_UV_WARN_I(ev[14]),
    .VIN_UV_FAULT_I(ev[15]), .CMD_INVALID_I(ev[16]), .DATA_INVALID_I(ev[17]),
    .PEC_ERROR_I(ev[18]), .COMM_OTHER_I(ev[19]), .INTER_CONVERTER_BUS_ERR_I(ev[20]),
    .SYNC_LOSS_I(ev[21]), .AUX_VOLTAGE_MONITOR_INPUT_I(mon),
    .MONITOR_UNDERVOLTAGE_THRESHOLD_I(uv_thr), .MONITOR_OVERVOLTAGE_THRESHOLD_I(ov_thr),
    .READ_DATA_O(data), .READ_VALID_O(valid), .READ_HIT_O(hit), .SUMMARY_OTHER_O(so),
    .SUMMARY_CML_O(sc));
  status_host_model status_host_model_inst (
    .clk_i(clk), .data_i(data), .valid_i(valid), .hit_i(hit), .cmd_o(cmd), .rd_o(rd),
    .wr_o(wr), .page_o(pg), .clr_o(clr));
  function automatic logic [7:0] want(input int k, input logic p, input logic rp);
    return (TBL[k][15:8] inside {8'h7B, 8'h7D} && p != rp) ? 8'h00 : TBL[k][7:0];
  endfunction : want
  // Vendor byte from the monitor rules, warnings at a ten percent margin
  function automatic logic [7:0] mon_want(input logic [15:0] m, input logic [15:0] u,
                                          input logic [15:0] o);
    logic [7:0] b;
    b = 8'h00;
    b[5] = 32'(m) * 10 < 32'(u) * 9;
    b[4] = 32'(m) * 10 > 32'(o) * 11;
    b[1] = m < u;
    b[0] = m > o;
    return b;
  endfunction : mon_want
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One cycle of condition k on page p, then all conditions drop
  task automatic fire(input int k, input logic p);
    @(posedge clk);
    ev[k < 6 ? 2 * k + p : k + 6] <= 1'b1;
    @(posedge clk);
    ev <= '0;
  endtask : fire
  task automatic close_out();
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    foreach (CODES[i]) for (int p = 0; p < 2; p++) begin
      status_host_model_inst.rd(CODES[i], p[0], ans);
      chk(ans, 10'h300);
    end
    for (int k = 0; k < 16; k++) for (int p = 0; p < 2; p++) begin
      fire(k, p[0]);
      for (int r = 0; r < 2; r++) begin
        status_host_model_inst.rd(TBL[k][15:8], r[0], ans);
        chk(ans, {2'b11, want(k, p[0], r[0])});
      end
      chk({8'h00, so, sc}, {9'h001, TBL[k][15:8] == 8'h7E});
      status_host_model_inst.pulse(8'h00, 1'b0);
      status_host_model_inst.rd(TBL[k][15:8], p[0], ans);
      chk(ans, 10'h300);
    end
    foreach (MON[i]) begin
      @(posedge clk);
      mon <= MON[i][23:8];
      @(posedge clk);
      mon <= 16'd1000 + 16'($random(seed) & 511);
      status_host_model_inst.rd(8'h80, 1'b0, ans);
      chk(ans, {2'b11, MON[i][7:0]});
      chk({9'h000, so}, {9'h000, MON[i][7:0] != 8'h00});
      status_host_model_inst.pulse(8'h00, 1'b0);
    end
    foreach (CODES[i]) begin
      status_host_model_inst.pulse(CODES[i], 1'b1);
      status_host_model_inst.rd(CODES[i], 1'b0, ans);
      chk(ans, {2'b11, CODES[i] == 8'h7E ? 8'h02 : 8'h00});
      chk({9'h000, sc}, 10'h001);
      status_host_model_inst.pulse(8'h00, 1'b0);
    end
    // Random thresholds for one cycle, then back to a quiet setting
    repeat (24) begin
      rm = 16'($random(seed));
      ru = 16'($random(seed));
      ro = 16'($random(seed));
      @(posedge clk);
      mon    <= rm;
      uv_thr <= ru;
      ov_thr <= ro;
      @(posedge clk);
      mon    <= 16'd1500;
      uv_thr <= 16'd1000;
      ov_thr <= 16'd2000;
      status_host_model_inst.rd(8'h80, 1'b0, ans);
      chk(ans, {2'b11, mon_want(rm, ru, ro)});
      status_host_model_inst.pulse(8'h00, 1'b0);
    end
    // Reset in mid-run must drop a latched flag
    fire(0, 1'b0);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    status_host_model_inst.rd(8'h7B, 1'b0, ans);
    chk(ans, 10'h300);
    chk({9'h000, so}, 10'h000);
    repeat (40) begin
      rc = 8'($random(seed));
      status_host_model_inst.rd(rc, 1'($random(seed)), ans);
      chk(ans, {1'b1, rc inside {8'h7B, 8'h7C, 8'h7D, 8'h7E, 8'h80}, 8'h00});
    end
    close_out();
  end
  initial begin
    #100000;
    n_mismatch++;
    close_out();
  end
endmodule : fault_status_bank_tb_top
